// >>> hdl/cio_pkg.sv
// Purpose: Shared constants and carriers for the I/O object map.
// Assumes: Objects are addressed by 16-bit index and 8-bit sub-index.
// Notes: Reset values of all writable objects are zero.
package cio_pkg;

  // ************************************************************
  // Object indexes
  // ************************************************************
  localparam logic [15:0] IDX_FUNC_SEL = 16'h2000;
  localparam logic [15:0] IDX_IN_BYTES = 16'h6000;
  localparam logic [15:0] IDX_IN_WORD = 16'h6100;
  localparam logic [15:0] IDX_IN_POL = 16'h6102;
  localparam logic [15:0] IDX_IN_MASK = 16'h6103;
  localparam logic [15:0] IDX_OUT_BYTES = 16'h6200;
  localparam logic [15:0] IDX_OUT_WORD = 16'h6300;
  localparam logic [15:0] IDX_OUT_POL = 16'h6302;
  localparam logic [15:0] IDX_FB_MODE = 16'h6306;
  localparam logic [15:0] IDX_FB_VALUE = 16'h6307;
  localparam logic [15:0] IDX_OUT_MASK = 16'h6308;

  // ************************************************************
  // Sub-indexes, field layouts, reset values
  // ************************************************************
  localparam logic [7:0] SUB_LOW = 8'h01;
  localparam logic [7:0] SUB_HIGH = 8'h02;
  // Assigned bits: inputs 0-3 in bits 3:0, inputs 10-17 in bits 15:8
  localparam logic [15:0] IN_BITS = 16'hFF0F;
  // Assigned bits: outputs 4-7 in bits 7:4
  localparam logic [15:0] OUT_BITS = 16'h00F0;
  localparam int OUT_LSB = 4;
  localparam int IN_HI_LSB = 8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_PINS = 4'h0;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] subidx;
    logic [15:0] wdata;
  } cio_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } cio_rsp_t;

endpackage : cio_pkg

// >>> hdl/cio_object_map.sv
// Purpose: Object-dictionary register bank for a 4-in / 4-out / 8-in splitter.
// Assumes: Pin inputs are synchronous to clk_sys; comm_fault is a level.
// Notes: One access per request; answer follows one cycle later.
//
// Operation
// - Byte config object covers channels 10-17
// - Config bit n picks diagnostics for channel 10+n
// - Input byte sub 1: channels 0-3, rest zero
// - Input byte sub 1 mirrors input word low
// - Input byte sub 2 mirrors input word high
// - Input word: bits 3:0 and 15:8 assigned
// - Input polarity and masking use input layout
// - Input objects are words except two bytes
// - Output word drives outputs 4-7 from 7:4
// - Output byte sub 1 aliases output word low
// - Output polarity bits 7:4 only
// - Fallback mode bits 7:4 only
// - Fallback value bits 7:4 only
// - Output masking bits 7:4 only
// - Communication error applies each unmasked output's fallback mode
`timescale 1ns/100ps
`default_nettype none

module cio_object_map (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire cio_pkg::cio_req_t obj_req,
  output var cio_pkg::cio_rsp_t obj_rsp,
  input wire logic [3:0] chan_in_lo,
  input wire logic [7:0] chan_in_hi,
  input wire logic [7:0] diag_in_hi,
  input wire logic comm_fault,
  output logic [3:0] out_pins
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] func_sel;
    logic [15:0] in_word;
    logic [15:0] in_pol;
    logic [15:0] in_mask;
    logic [15:0] out_word;
    logic [15:0] out_pol;
    logic [15:0] fb_mode;
    logic [15:0] fb_value;
    logic [15:0] out_mask;
    logic [3:0] pins;
    cio_pkg::cio_rsp_t rsp;
  } cio_state_t;

  cio_state_t s;
  cio_state_t next_s;

  // Merge new data into old under a mask of writable bits
  function automatic logic [15:0] cio_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [15:0] keep);
    cio_merge = (new_v & keep) | (old_v & ~keep);
  endfunction : cio_merge

  logic [15:0] raw_in;
  logic [15:0] logic_in;
  logic [3:0] norm_out;
  logic [3:0] fb_out;
  logic wr;
  logic rd;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [15:0] wd;

  always_comb begin
    wr = obj_req.valid & obj_req.write;
    rd = obj_req.valid & ~obj_req.write;
    idx = obj_req.index;
    sub = obj_req.subidx;
    wd = obj_req.wdata;
  end

  // ************************************************************
  // Channel paths
  // ************************************************************
  always_comb begin
    raw_in = 16'h0000;
    raw_in[3:0] = chan_in_lo;
    for (int i = 0; i < 8; i++) begin
      raw_in[cio_pkg::IN_HI_LSB + i] = s.func_sel[i] ? diag_in_hi[i] : chan_in_hi[i];
    end
    logic_in = (raw_in ^ s.in_pol) & cio_pkg::IN_BITS;
    for (int i = 0; i < 4; i++) begin
      norm_out[i] = s.out_word[cio_pkg::OUT_LSB + i];
      // Fallback level is a logical value, so output polarity still applies to it
      fb_out[i] = s.fb_mode[cio_pkg::OUT_LSB + i]
                  ? s.fb_value[cio_pkg::OUT_LSB + i]
                  : s.pins[i] ^ s.out_pol[cio_pkg::OUT_LSB + i];
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.rsp.ack = 1'b0;
    next_s.rsp.err = 1'b0;
    // Masked inputs freeze their last reading
    next_s.in_word = cio_merge(s.in_word, logic_in, ~s.in_mask & cio_pkg::IN_BITS);
    for (int i = 0; i < 4; i++) begin
      if (s.out_mask[cio_pkg::OUT_LSB + i]) begin
        next_s.pins[i] = 1'b0;
      end else if (comm_fault) begin
        // Hold mode recomputes the present pin level, so the pin stays put
        next_s.pins[i] = fb_out[i] ^ s.out_pol[cio_pkg::OUT_LSB + i];
      end else begin
        next_s.pins[i] = norm_out[i] ^ s.out_pol[cio_pkg::OUT_LSB + i];
      end
    end
    if (obj_req.valid) begin
      next_s.rsp.ack = 1'b1;
      next_s.rsp.rdata = 16'h0000;
    end
    if (obj_req.valid && idx == cio_pkg::IDX_FUNC_SEL) begin
      if (sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else if (wr) begin
        next_s.func_sel = wd[7:0];
      end else if (rd) begin
        next_s.rsp.rdata = {8'h00, s.func_sel};
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_IN_BYTES) begin
      if (wr) begin
        next_s.rsp.err = 1'b1;
      end else if (sub == cio_pkg::SUB_LOW) begin
        next_s.rsp.rdata = {8'h00, s.in_word[7:0]};
      end else if (sub == cio_pkg::SUB_HIGH) begin
        next_s.rsp.rdata = {8'h00, s.in_word[15:8]};
      end else begin
        next_s.rsp.err = 1'b1;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_IN_WORD) begin
      if (wr || sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else begin
        next_s.rsp.rdata = s.in_word;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_IN_POL) begin
      if (sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else if (wr) begin
        next_s.in_pol = wd & cio_pkg::IN_BITS;
      end else begin
        next_s.rsp.rdata = s.in_pol;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_IN_MASK) begin
      if (sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else if (wr) begin
        next_s.in_mask = wd & cio_pkg::IN_BITS;
      end else begin
        next_s.rsp.rdata = s.in_mask;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_OUT_BYTES) begin
      if (sub == cio_pkg::SUB_LOW) begin
        if (wr) begin
          next_s.out_word = cio_merge(s.out_word, {8'h00, wd[7:0]}, cio_pkg::OUT_BITS);
        end else begin
          next_s.rsp.rdata = {8'h00, s.out_word[7:0]};
        end
      end else if (sub != cio_pkg::SUB_HIGH) begin
        // Sub-index 2 exists but carries no bits: reads zero, writes dropped
        next_s.rsp.err = 1'b1;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_OUT_WORD) begin
      if (sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else if (wr) begin
        next_s.out_word = wd & cio_pkg::OUT_BITS;
      end else begin
        next_s.rsp.rdata = s.out_word;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_OUT_POL) begin
      if (sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else if (wr) begin
        next_s.out_pol = wd & cio_pkg::OUT_BITS;
      end else begin
        next_s.rsp.rdata = s.out_pol;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_FB_MODE) begin
      if (sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else if (wr) begin
        next_s.fb_mode = wd & cio_pkg::OUT_BITS;
      end else begin
        next_s.rsp.rdata = s.fb_mode;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_FB_VALUE) begin
      if (sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else if (wr) begin
        next_s.fb_value = wd & cio_pkg::OUT_BITS;
      end else begin
        next_s.rsp.rdata = s.fb_value;
      end
    end else if (obj_req.valid && idx == cio_pkg::IDX_OUT_MASK) begin
      if (sub != cio_pkg::SUB_LOW) begin
        next_s.rsp.err = 1'b1;
      end else if (wr) begin
        next_s.out_mask = wd & cio_pkg::OUT_BITS;
      end else begin
        next_s.rsp.rdata = s.out_mask;
      end
    end else if (obj_req.valid) begin
      next_s.rsp.err = 1'b1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s.func_sel <= cio_pkg::RST_BYTE;
      s.in_word <= cio_pkg::RST_WORD;
      s.in_pol <= cio_pkg::RST_WORD;
      s.in_mask <= cio_pkg::RST_WORD;
      s.out_word <= cio_pkg::RST_WORD;
      s.out_pol <= cio_pkg::RST_WORD;
      s.fb_mode <= cio_pkg::RST_WORD;
      s.fb_value <= cio_pkg::RST_WORD;
      s.out_mask <= cio_pkg::RST_WORD;
      s.pins <= cio_pkg::RST_PINS;
      s.rsp <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    obj_rsp = s.rsp;
    out_pins = s.pins;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence seq_wr(logic [15:0] i, logic [7:0] sb);
    obj_req.valid && obj_req.write && obj_req.index == i && obj_req.subidx == sb;
  endsequence

  sequence seq_rd(logic [15:0] i, logic [7:0] sb);
    obj_req.valid && !obj_req.write && obj_req.index == i && obj_req.subidx == sb;
  endsequence

  AST_ACK_ONE: assert property (obj_req.valid |=> obj_rsp.ack ##1 !obj_rsp.ack
                                || $past(obj_req.valid, 1))
    else $error("request not answered in one cycle");
  AST_CFG_WRITE: assert property (
    seq_wr(cio_pkg::IDX_FUNC_SEL, cio_pkg::SUB_LOW) |=> s.func_sel == $past(obj_req.wdata[7:0]))
    else $error("function select write lost");
  AST_IN_BYTE_ALIAS: assert property (
    seq_rd(cio_pkg::IDX_IN_BYTES, cio_pkg::SUB_LOW)
    |=> obj_rsp.rdata == {8'h00, $past(s.in_word[7:0])} && !obj_rsp.err)
    else $error("input byte does not mirror word low byte");
  AST_IN_UNASSIGNED: assert property (s.in_word[7:4] == 4'h0 && s.in_pol[7:4] == 4'h0)
    else $error("unassigned input bits not zero");
  AST_OUT_WRITE: assert property (
    seq_wr(cio_pkg::IDX_OUT_WORD, cio_pkg::SUB_LOW)
    |=> s.out_word == ($past(obj_req.wdata) & 16'h00F0))
    else $error("output word write not masked to bits 7:4");
  AST_FALLBACK: assert property (
    comm_fault && !s.out_mask[4] && s.fb_mode[4]
    |=> out_pins[0] == $past(s.fb_value[4] ^ s.out_pol[4]))
    else $error("fallback value not applied on fault");
  AST_HOLD: assert property (
    comm_fault && !s.out_mask[6] && !s.fb_mode[6] |=> out_pins[2] == $past(out_pins[2]))
    else $error("hold mode output changed on fault");
  AST_OUT_POL: assert property (
    !comm_fault && !s.out_mask[5] |=> out_pins[1] == $past(s.out_word[5] ^ s.out_pol[5]))
    else $error("output polarity not applied");
  AST_IN_POL: assert property (
    !s.in_mask[0] |=> s.in_word[0] == $past(chan_in_lo[0] ^ s.in_pol[0]))
    else $error("input polarity not applied");
  AST_RO_ERR: assert property (
    seq_wr(cio_pkg::IDX_IN_WORD, cio_pkg::SUB_LOW) |=> obj_rsp.err ##1 !obj_rsp.err
    || $past(obj_req.valid, 1))
    else $error("write to read-only input word accepted");
  AST_OUT_MASK: assert property (
    s.out_mask[7] |=> out_pins[3] == 1'b0)
    else $error("masked output not forced low");

  // Byte views and read-back paths
  AST_IN_BYTE_HIGH: assert property (
    seq_rd(cio_pkg::IDX_IN_BYTES, cio_pkg::SUB_HIGH)
    |=> obj_rsp.rdata == {8'h00, $past(s.in_word[15:8])} && !obj_rsp.err)
    else $error("input byte two does not mirror word high byte");
  AST_IN_WORD_READ: assert property (
    seq_rd(cio_pkg::IDX_IN_WORD, cio_pkg::SUB_LOW)
    |=> obj_rsp.rdata == $past(s.in_word) && !obj_rsp.err)
    else $error("input word read returned wrong data");
  AST_CFG_READ: assert property (
    seq_rd(cio_pkg::IDX_FUNC_SEL, cio_pkg::SUB_LOW)
    |=> obj_rsp.rdata == {8'h00, $past(s.func_sel)} && !obj_rsp.err)
    else $error("function select read returned wrong data");
  AST_OUT_BYTE_ALIAS: assert property (
    seq_wr(cio_pkg::IDX_OUT_BYTES, cio_pkg::SUB_LOW)
    |=> s.out_word == ($past(obj_req.wdata) & 16'h00F0) && !obj_rsp.err)
    else $error("output byte write did not land in word low byte");
  AST_OUT_BYTE_SPARE: assert property (
    seq_wr(cio_pkg::IDX_OUT_BYTES, cio_pkg::SUB_HIGH)
    |=> $stable(s.out_word) && obj_rsp.ack && !obj_rsp.err)
    else $error("output byte two write changed state or was refused");
  AST_RO_BYTE_ERR: assert property (
    seq_wr(cio_pkg::IDX_IN_BYTES, cio_pkg::SUB_LOW) |=> obj_rsp.ack && obj_rsp.err)
    else $error("write to read-only input byte accepted");

  // Channel paths and unassigned bits
  AST_DIAG_SELECT: assert property (
    !s.in_mask[8]
    |=> s.in_word[8] == $past((s.func_sel[0] ? diag_in_hi[0] : chan_in_hi[0]) ^ s.in_pol[8]))
    else $error("channel 10 source or polarity wrong");
  AST_FB_VALUE: assert property (
    comm_fault && !s.out_mask[7] && s.fb_mode[7]
    |=> out_pins[3] == $past(s.fb_value[7] ^ s.out_pol[7]))
    else $error("fallback value not applied to last output");
  AST_IN_REG_UNASSIGNED: assert property (
    (s.in_mask & ~cio_pkg::IN_BITS) == 16'h0000)
    else $error("unassigned input masking bits set");
  AST_OUT_UNASSIGNED: assert property (
    (s.out_word & ~cio_pkg::OUT_BITS) == 16'h0000
    && (s.out_pol & ~cio_pkg::OUT_BITS) == 16'h0000
    && (s.fb_mode & ~cio_pkg::OUT_BITS) == 16'h0000
    && (s.fb_value & ~cio_pkg::OUT_BITS) == 16'h0000
    && (s.out_mask & ~cio_pkg::OUT_BITS) == 16'h0000)
    else $error("unassigned output bits set");

endmodule : cio_object_map

`default_nettype wire

// >>> tb/cio_master.sv
// Purpose: Behavioural fieldbus master that issues object accesses.
// Assumes: One access at a time; the answer arrives one cycle after the request.
// Notes: Idle request fields carry inverted last values so stale data never matches.
`timescale 1ns/100ps
`default_nettype none

module cio_master (
  input wire logic clk_sys,
  output var cio_pkg::cio_req_t req,
  input wire cio_pkg::cio_rsp_t rsp
);
  initial req = '0;

  // ************************************************************
  // Single access: request for one cycle, answer sampled next edge
  // ************************************************************
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] st);
    @(posedge clk_sys);
    #1;
    req <= {1'b1, wr, idx, sub, wd};
    @(posedge clk_sys);
    #1;
    rd = rsp.rdata;
    st = {rsp.ack, rsp.err};
    req <= {1'b0, ~wr, ~idx, ~sub, ~wd};
  endtask : access
endmodule : cio_master
`default_nettype wire

// >>> tb/cio_object_map_bench.sv
// Purpose: Self-checking bench for the I/O object map.
// Assumes: Fallback is tested with output masking cleared.
// Notes: Random values come from one fixed seed.
`timescale 1ns/100ps
`default_nettype none

module cio_object_map_bench;
  logic clk_sys, rst_n, comm_fault;
  logic [3:0] chan_in_lo, out_pins, held;
  logic [7:0] chan_in_hi, diag_in_hi;
  cio_pkg::cio_req_t obj_req;
  cio_pkg::cio_rsp_t obj_rsp;
  int fail_count, total_checks, cycles;
  logic [15:0] rd, sel, pol, wv, mv, fv, ow, iw;
  logic [15:0] idx_tab [8] = '{16'h2000, 16'h6102, 16'h6103, 16'h6300,
                               16'h6302, 16'h6306, 16'h6307, 16'h6308};
  logic [15:0] msk_tab [8] = '{16'h00FF, 16'hFF0F, 16'hFF0F, 16'h00F0,
                               16'h00F0, 16'h00F0, 16'h00F0, 16'h00F0};

  cio_object_map dut (.clk_sys(clk_sys), .rst_n(rst_n), .obj_req(obj_req),
    .obj_rsp(obj_rsp), .chan_in_lo(chan_in_lo), .chan_in_hi(chan_in_hi),
    .diag_in_hi(diag_in_hi), .comm_fault(comm_fault), .out_pins(out_pins));
  cio_master m (.clk_sys(clk_sys), .req(obj_req), .rsp(obj_rsp));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] exp_in(logic [7:0] s, logic [3:0] lo, logic [7:0] hi,
      logic [7:0] dg, logic [15:0] p);
    return ({(s & dg) | (~s & hi), 4'h0, lo} ^ p) & cio_pkg::IN_BITS;
  endfunction : exp_in

  function automatic logic [3:0] exp_pin(logic f, logic [3:0] o, logic [3:0] p,
      logic [3:0] md, logic [3:0] v, logic [3:0] h);
    return f ? ((md & (v ^ p)) | (~md & h)) : (o ^ p);
  endfunction : exp_pin

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rw(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [15:0] wd, input logic [1:0] es);
    logic [1:0] st;
    m.access(wr, idx, sub, wd, rd, st);
    check({14'h0, st}, {14'h0, es});
  endtask : rw

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    comm_fault = 1'b0;
    chan_in_lo = 4'h0;
    chan_in_hi = 8'h00;
    diag_in_hi = 8'h00;
    void'($urandom(32'h13a1));
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rw(1'b0, idx_tab[i], 8'h01, 16'h0000, 2'b10);
      check(rd, 16'h0000);
    end
    // Writable objects keep only their assigned bits
    for (int i = 0; i < 8; i++) begin
      wv = 16'($urandom);
      rw(1'b1, idx_tab[i], 8'h01, wv, 2'b10);
      rw(1'b0, idx_tab[i], 8'h01, 16'h0000, 2'b10);
      check(rd, wv & msk_tab[i]);
    end
    rw(1'b1, 16'h6103, 8'h01, 16'h0000, 2'b10);
    for (int k = 0; k < 5; k++) begin
      sel = 16'($urandom);
      pol = 16'($urandom);
      rw(1'b1, 16'h2000, 8'h01, sel, 2'b10);
      rw(1'b1, 16'h6102, 8'h01, pol, 2'b10);
      chan_in_lo = 4'($urandom);
      chan_in_hi = 8'($urandom);
      diag_in_hi = 8'($urandom);
      settle();
      iw = exp_in(sel[7:0], chan_in_lo, chan_in_hi, diag_in_hi, pol);
      rw(1'b0, 16'h6100, 8'h01, 16'h0000, 2'b10);
      check(rd, iw);
      rw(1'b0, 16'h6000, 8'h01, 16'h0000, 2'b10);
      check(rd, {8'h00, iw[7:0]});
      rw(1'b0, 16'h6000, 8'h02, 16'h0000, 2'b10);
      check(rd, {8'h00, iw[15:8]});
    end
    // Masked inputs freeze at their last value
    rw(1'b1, 16'h6103, 8'h01, 16'hFFFF, 2'b10);
    chan_in_lo = ~chan_in_lo;
    chan_in_hi = ~chan_in_hi;
    diag_in_hi = ~diag_in_hi;
    settle();
    rw(1'b0, 16'h6100, 8'h01, 16'h0000, 2'b10);
    check(rd, iw);
    rw(1'b1, 16'h6308, 8'h01, 16'h0000, 2'b10);
    rw(1'b1, 16'h6306, 8'h01, 16'h0000, 2'b10);
    for (int k = 0; k < 5; k++) begin
      ow = 16'($urandom);
      pol = 16'($urandom);
      rw(1'b1, 16'h6302, 8'h01, pol, 2'b10);
      rw(1'b1, 16'h6200, 8'h01, ow, 2'b10);
      settle();
      check({12'h000, out_pins}, {12'h000, ow[7:4] ^ pol[7:4]});
      rw(1'b0, 16'h6300, 8'h01, 16'h0000, 2'b10);
      check(rd, ow & cio_pkg::OUT_BITS);
      rw(1'b0, 16'h6200, 8'h01, 16'h0000, 2'b10);
      check(rd, ow & cio_pkg::OUT_BITS);
    end
    rw(1'b1, 16'h6200, 8'h02, 16'hFFFF, 2'b10);
    rw(1'b0, 16'h6200, 8'h02, 16'h0000, 2'b10);
    check(rd, 16'h0000);
    rw(1'b0, 16'h6300, 8'h01, 16'h0000, 2'b10);
    check(rd, ow & cio_pkg::OUT_BITS);
    rw(1'b1, 16'h6308, 8'h01, 16'h00F0, 2'b10);
    settle();
    check({12'h000, out_pins}, 16'h0000);
    rw(1'b1, 16'h6308, 8'h01, 16'h0000, 2'b10);
    settle();
    held = ow[7:4] ^ pol[7:4];
    // Pins 4 and 7 fall back and pin 6 holds, so every fallback assertion is reached
    mv = (16'($urandom) & 16'hFFBF) | 16'h0090;
    fv = 16'($urandom);
    rw(1'b1, 16'h6306, 8'h01, mv, 2'b10);
    rw(1'b1, 16'h6307, 8'h01, fv, 2'b10);
    comm_fault = 1'b1;
    wv = {12'h000, exp_pin(1'b1, 4'h0, pol[7:4], mv[7:4], fv[7:4], held)};
    settle();
    check({12'h000, out_pins}, wv);
    ow = ~ow;
    rw(1'b1, 16'h6300, 8'h01, ow, 2'b10);
    settle();
    check({12'h000, out_pins}, wv);
    comm_fault = 1'b0;
    wv = {12'h000, exp_pin(1'b0, ow[7:4], pol[7:4], 4'h0, 4'h0, 4'h0)};
    settle();
    check({12'h000, out_pins}, wv);
    // Refused accesses: read-only inputs, unknown index, bad sub-index
    rw(1'b1, 16'h6000, 8'h01, 16'hFFFF, 2'b11);
    rw(1'b1, 16'h6100, 8'h01, 16'hFFFF, 2'b11);
    rw(1'b0, 16'h6001, 8'h01, 16'h0000, 2'b11);
    rw(1'b0, 16'h6300, 8'h02, 16'h0000, 2'b11);
    rw(1'b0, 16'h6000, 8'h03, 16'h0000, 2'b11);
    rw(1'b1, 16'h2000, 8'h02, 16'hFFFF, 2'b11);
    rw(1'b0, 16'h2000, 8'h01, 16'h0000, 2'b10);
    check(rd, {8'h00, sel[7:0]});
    // Reset in mid-run clears every object and the pins
    rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    check({12'h000, out_pins}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rw(1'b0, idx_tab[i], 8'h01, 16'h0000, 2'b10);
      check(rd, 16'h0000);
    end
    wrap_up();
  end
endmodule : cio_object_map_bench
`default_nettype wire
